// ---- src/pei_event_irq.sv ----
// Event status, interrupt gating, page select and false carrier count for one port
//
// Overview of operation
// - A status bit sets on its event and holds until the status register is read.
// - Unless the test bit is set, interrupt needs the event enable and the global interrupt gate both set.
// - Status bits latch whether or not any enable is set.
// - Bit 15 is link quality pending; resets low; cleared by reading.
// - Bit 14 is energy detect pending; resets low; cleared by reading.
// - Bit 13 is link status change pending; resets low; cleared by reading.
// - Bit 12 is speed change pending; resets low; cleared by reading.
// - Bit 11 is duplex change pending; resets low; cleared by reading.
// - Bit 10 is autonegotiation done pending; resets low; cleared by reading.
// - Bit 9 is false carrier counter half-full pending; resets low; read clears.
// - Bit 8 is receive error counter half-full pending; resets low; read clears.
// - Bits 7..0 are writable enables for status bits 15..8, in order.
// - Two-bit page field picks which bank answers at 14h to 1Fh.
// - Page 0 is extended registers, page 2 diagnostics, page 1 reserved.
// - Eight-bit false carrier counter counts each false carrier event, resets zero.
// - The false carrier counter sticks at FFh instead of wrapping.
// - The false carrier counter is read-only and clears on each read made while page 0 is selected.
// - Global gate enables event interrupts; output enable turns the pin into interrupt.
// - Test interrupt bit forces the interrupt while it stays set.
`timescale 1ns/1ps

module pei_event_irq
  import pei_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,

  // Management register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   reg_rvalid,

  // Event sources from the port logic, one-cycle pulses except the receive error counter MSB, which is a level
  input  wire logic              link_quality_event,
  input  wire logic              energy_detect_event,
  input  wire logic              link_change_event,
  input  wire logic              speed_change_event,
  input  wire logic              duplex_change_event,
  input  wire logic              autoneg_done_event,
  input  wire logic              false_carrier_event,
  input  wire logic              rx_error_count_msb,

  // Shared power-down or interrupt pin
  input  wire logic              powerdown_or_irq_pin_in,
  output logic                   powerdown_or_irq_pin_out,
  output logic                   powerdown_or_irq_pin_oe,

  // Status toward the port logic
  output logic                   powerdown_req,
  output logic [PAGE_W-1:0]      page_select
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [NUM_EVENTS-1:0] pending_ff;
  logic [NUM_EVENTS-1:0] enable_ff;
  logic [CTRL_W-1:0]     ctrl_ff;
  logic [PAGE_W-1:0]     page_ff;
  logic [FC_W-1:0]       fc_count_ff;
  logic                  rx_msb_ff;
  logic [DATA_W-1:0]     rdata_ff;
  logic                  rvalid_ff;
  logic                  pin_out_ff;
  logic                  pin_oe_ff;
  logic                  pd_meta_ff;
  logic                  pd_sync2_ff;
  logic                  pd_sync3_ff;
  logic                  pd_level_ff;
  logic                  pd_req_ff;

  logic [NUM_EVENTS-1:0] nxt_pending;
  logic [FC_W-1:0]       nxt_fc_count;
  logic [DATA_W-1:0]     nxt_rdata;
  logic                  nxt_irq;
  logic                  nxt_pd_level;
  logic [NUM_EVENTS-1:0] nxt_enable;
  logic [CTRL_W-1:0]     nxt_ctrl;
  logic [PAGE_W-1:0]     nxt_page;
  logic                  nxt_pin_out;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire hit_ctrl   = (reg_addr == ADDR_INT_CTRL);
  wire hit_status = (reg_addr == ADDR_EVT_STATUS);
  wire hit_page   = (reg_addr == ADDR_PAGE_SEL);
  wire in_paged   = (reg_addr >= ADDR_FC_COUNT) && (reg_addr <= ADDR_PAGED_LAST);
  // Counter answers only while the extended page is selected
  wire hit_fc     = (reg_addr == ADDR_FC_COUNT) && (page_ff == PAGE_EXTENDED);

  // ------------------------------------------------------------
  // Strobes
  // ------------------------------------------------------------
  // Qualified by decode only; the host never raises both at once
  wire wr_ctrl    = reg_wr && hit_ctrl;
  wire wr_enable  = reg_wr && hit_status;
  wire wr_page    = reg_wr && hit_page;
  wire rd_status  = reg_rd && hit_status;
  wire rd_fc      = reg_rd && hit_fc;

  // ------------------------------------------------------------
  // Event capture
  // ------------------------------------------------------------
  // Half-full is the moment the counter MSB goes high
  wire fc_half_rise = nxt_fc_count[FC_HALF_BIT] && !fc_count_ff[FC_HALF_BIT];
  wire rx_half_rise = rx_error_count_msb && !rx_msb_ff;

  // ------------------------------------------------------------
  // Event sources
  // ------------------------------------------------------------
  wire [NUM_EVENTS-1:0] event_in;
  assign event_in[EV_LINK_QUALITY] = link_quality_event;
  assign event_in[EV_ENERGY]       = energy_detect_event;
  assign event_in[EV_LINK]         = link_change_event;
  assign event_in[EV_SPEED]        = speed_change_event;
  assign event_in[EV_DUPLEX]       = duplex_change_event;
  assign event_in[EV_AUTONEG]      = autoneg_done_event;
  assign event_in[EV_FC_HALF]      = fc_half_rise;
  assign event_in[EV_RX_ERR_HALF]  = rx_half_rise;

  // ------------------------------------------------------------
  // Pending status
  // ------------------------------------------------------------
  // Latching ignores every enable; a new event beats the read that clears
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_pending
      assign nxt_pending[gi] = event_in[gi] || (pending_ff[gi] && !rd_status);
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pending_ff <= EVT_RESET;
    end else begin
      pending_ff <= nxt_pending;
    end
  end

  // Previous level of the external counter MSB, for edge detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_msb_ff <= 1'b0;
    end else begin
      rx_msb_ff <= rx_error_count_msb;
    end
  end

  // ------------------------------------------------------------
  // Enables and interrupt control
  // ------------------------------------------------------------
  // Reserved bits are never stored, so they read back as zero for free
  assign nxt_enable = wr_enable ? reg_wdata[NUM_EVENTS-1:0] : enable_ff;
  assign nxt_ctrl   = wr_ctrl ? reg_wdata[CTRL_W-1:0] : ctrl_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable_ff <= EVT_RESET;
    end else begin
      enable_ff <= nxt_enable;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_ff <= CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ------------------------------------------------------------
  // Page select
  // ------------------------------------------------------------
  // Value 1 is stored as written; it just selects an empty bank here
  assign nxt_page = wr_page ? reg_wdata[PAGE_W-1:0] : page_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      page_ff <= PAGE_RESET;
    end else begin
      page_ff <= nxt_page;
    end
  end

  // ------------------------------------------------------------
  // False carrier counter
  // ------------------------------------------------------------
  // Saturation is tested before the add so FFh never rolls over to zero
  wire            fc_at_max   = (fc_count_ff == FC_MAX);
  wire            fc_step     = false_carrier_event && !fc_at_max;
  wire [FC_W-1:0] fc_plus_one = fc_count_ff + FC_ONE;

  // A read clears the count, but an event in the same cycle is kept as one
  always_comb begin
    if (rd_fc) begin
      nxt_fc_count = false_carrier_event ? FC_ONE : FC_RESET;
    end else if (fc_step) begin
      nxt_fc_count = fc_plus_one;
    end else begin
      nxt_fc_count = fc_count_ff;
    end
  end

  // Counting goes on under every page; only the visibility is paged
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fc_count_ff <= FC_RESET;
    end else begin
      fc_count_ff <= nxt_fc_count;
    end
  end

  // ------------------------------------------------------------
  // Interrupt generation
  // ------------------------------------------------------------
  wire [NUM_EVENTS-1:0] armed;
  genvar gj;
  generate
    for (gj = 0; gj < NUM_EVENTS; gj++) begin : g_armed
      assign armed[gj] = pending_ff[gj] && enable_ff[gj];
    end
  endgenerate
  wire any_enabled = |armed;
  wire gate_on     = ctrl_ff[CTRL_GATE_BIT];
  wire test_on     = ctrl_ff[CTRL_TEST_BIT];
  wire drive_pin   = ctrl_ff[CTRL_OE_BIT];

  // The test bit bypasses both the gate and the enables on purpose
  assign nxt_irq = test_on || (gate_on && any_enabled);

  // The pin signals an interrupt low, like an open-drain request line
  assign nxt_pin_out = !nxt_irq;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_out_ff <= 1'b1;
    end else begin
      pin_out_ff <= nxt_pin_out;
    end
  end

  // Direction follows the control bit one cycle late, like the level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_oe_ff <= 1'b0;
    end else begin
      pin_oe_ff <= drive_pin;
    end
  end

  // ------------------------------------------------------------
  // Power-down input path
  // ------------------------------------------------------------
  // Three stages; a level counts only once the last two agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pd_meta_ff  <= 1'b1;
      pd_sync2_ff <= 1'b1;
      pd_sync3_ff <= 1'b1;
    end else begin
      pd_meta_ff  <= powerdown_or_irq_pin_in;
      pd_sync2_ff <= pd_meta_ff;
      pd_sync3_ff <= pd_sync2_ff;
    end
  end

  // A single disagreeing sample is treated as a glitch and ignored
  wire pd_agree = (pd_sync2_ff == pd_sync3_ff);
  assign nxt_pd_level = pd_agree ? pd_sync3_ff : pd_level_ff;

  // ------------------------------------------------------------
  // Power-down request
  // ------------------------------------------------------------
  // While the pin is an interrupt output its level means nothing as a request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pd_level_ff <= 1'b1;
      pd_req_ff   <= 1'b0;
    end else begin
      pd_level_ff <= nxt_pd_level;
      pd_req_ff   <= !drive_pin && !nxt_pd_level;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Control, page and counter words are zero padded so reserved bits can never leak state
  wire [DATA_W-1:0] ctrl_word   = {{(DATA_W-CTRL_W){1'b0}}, ctrl_ff};
  wire [DATA_W-1:0] status_word = {pending_ff, enable_ff};
  wire [DATA_W-1:0] page_word   = {{(DATA_W-PAGE_W){1'b0}}, page_ff};
  wire [DATA_W-1:0] fc_word     = {{(DATA_W-FC_W){1'b0}}, fc_count_ff};

  // Unused addresses and the other pages read as zero
  always_comb begin
    nxt_rdata = RDATA_ZERO;
    if (hit_ctrl) begin
      nxt_rdata = ctrl_word;
    end else if (hit_status) begin
      nxt_rdata = status_word;
    end else if (hit_page) begin
      nxt_rdata = page_word;
    end else if (hit_fc) begin
      nxt_rdata = fc_word;
    end else if (in_paged) begin
      nxt_rdata = RDATA_ZERO;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_ff <= RDATA_ZERO;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Valid is a pulse one cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Every output is a flop; nothing combinational reaches a pin
  assign reg_rdata                = rdata_ff;
  assign reg_rvalid               = rvalid_ff;
  assign powerdown_or_irq_pin_out = pin_out_ff;
  assign powerdown_or_irq_pin_oe  = pin_oe_ff;
  assign powerdown_req            = pd_req_ff;
  assign page_select              = page_ff;

endmodule

// ---- src/pei_pkg.sv ----
// Constants for the port event interrupt and paging block
package pei_pkg;

  // ------------------------------------------------------------
  // Management register map
  // ------------------------------------------------------------
  localparam int          ADDR_W          = 5;
  localparam int          DATA_W          = 16;
  localparam logic [4:0]  ADDR_INT_CTRL   = 5'h11;
  localparam logic [4:0]  ADDR_EVT_STATUS = 5'h12;
  localparam logic [4:0]  ADDR_PAGE_SEL   = 5'h13;
  localparam logic [4:0]  ADDR_FC_COUNT   = 5'h14;
  localparam logic [4:0]  ADDR_PAGED_LAST = 5'h1f;

  // ------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------
  localparam int          NUM_EVENTS      = 8;
  localparam int          STATUS_LSB      = 8;
  localparam int          CTRL_TEST_BIT   = 2;
  localparam int          CTRL_GATE_BIT   = 1;
  localparam int          CTRL_OE_BIT     = 0;
  localparam int          CTRL_W          = 3;
  localparam int          PAGE_W          = 2;
  localparam int          FC_W            = 8;
  localparam int          FC_HALF_BIT     = 7;

  // Event index inside the enable byte; status sits STATUS_LSB higher
  localparam int          EV_LINK_QUALITY = 7;
  localparam int          EV_ENERGY       = 6;
  localparam int          EV_LINK         = 5;
  localparam int          EV_SPEED        = 4;
  localparam int          EV_DUPLEX       = 3;
  localparam int          EV_AUTONEG      = 2;
  localparam int          EV_FC_HALF      = 1;
  localparam int          EV_RX_ERR_HALF  = 0;

  // ------------------------------------------------------------
  // Values and resets
  // ------------------------------------------------------------
  localparam logic [1:0]  PAGE_EXTENDED   = 2'h0;
  localparam logic [1:0]  PAGE_RESERVED   = 2'h1;
  localparam logic [1:0]  PAGE_DIAG       = 2'h2;
  localparam logic [7:0]  FC_MAX          = 8'hff;
  localparam logic [7:0]  FC_ONE          = 8'h01;
  localparam logic [7:0]  FC_RESET        = 8'h00;
  localparam logic [7:0]  EVT_RESET       = 8'h00;
  localparam logic [2:0]  CTRL_RESET      = 3'h0;
  localparam logic [1:0]  PAGE_RESET      = 2'h0;
  localparam logic [15:0] RDATA_ZERO      = 16'h0000;

endpackage

// ---- tb/pei_event_irq_properties.sv ----
// Checker for the port event interrupt block
`timescale 1ns/1ps
module pei_event_irq_props
  import pei_pkg::*;
(
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Events, pin and status
  input wire logic              link_quality_event,
  input wire logic              speed_change_event,
  input wire logic              false_carrier_event,
  input wire logic              powerdown_or_irq_pin_out,
  input wire logic              powerdown_or_irq_pin_oe,
  input wire logic              powerdown_req,
  input wire logic [PAGE_W-1:0] page_select
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic rd_st = reg_rd && reg_addr == ADDR_EVT_STATUS;
  wire logic rd_fc = reg_rd && reg_addr == ADDR_FC_COUNT && page_select == PAGE_EXTENDED && !false_carrier_event;
  wire logic wr_ic = reg_wr && reg_addr == ADDR_INT_CTRL;
  property p_oe; wr_ic |=> ##1 powerdown_or_irq_pin_oe == $past(reg_wdata[CTRL_OE_BIT], 2); endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_page; reg_wr && reg_addr == ADDR_PAGE_SEL |=> page_select == $past(reg_wdata[1:0]); endproperty
  a_page: assert property (p_page) else $error("page field wrong");
  property p_pg_rsv; reg_rd && reg_addr == ADDR_PAGE_SEL |=> reg_rdata[15:2] == 14'h0000; endproperty
  a_pg_rsv: assert property (p_pg_rsv) else $error("page upper bits set");
  property p_fc_rsv; reg_rd && reg_addr == ADDR_FC_COUNT |=> reg_rdata[15:8] == 8'h00; endproperty
  a_fc_rsv: assert property (p_fc_rsv) else $error("counter upper bits set");
  property p_test; wr_ic && reg_wdata[2:0] == 3'h5 |=> ##[0:1] !powerdown_or_irq_pin_out; endproperty
  a_test: assert property (p_test) else $error("test interrupt missing");
  property p_pd; $past(powerdown_or_irq_pin_oe) && powerdown_or_irq_pin_oe |-> !powerdown_req; endproperty
  a_pd: assert property (p_pd) else $error("power-down while pin drives");
  property p_lq; link_quality_event ##1 !reg_rd ##1 rd_st |=> reg_rdata[15]; endproperty
  a_lq: assert property (p_lq) else $error("link quality not latched");
  property p_spd; speed_change_event ##1 !reg_rd ##1 rd_st |=> reg_rdata[12]; endproperty
  a_spd: assert property (p_spd) else $error("speed change not latched");
  property p_fc_clr; rd_fc ##1 !false_carrier_event ##1 rd_fc |=> reg_rdata[7:0] == 8'h00; endproperty
  a_fc_clr: assert property (p_fc_clr) else $error("counter not cleared by read");
  c_sat: cover property (rd_fc ##1 reg_rdata[7:0] == FC_MAX);
  c_irq: cover property (powerdown_or_irq_pin_oe && !powerdown_or_irq_pin_out);
  c_pd: cover property (powerdown_req);
endmodule
bind pei_event_irq pei_event_irq_props u_props (.sys_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rdata, .link_quality_event, .speed_change_event, .false_carrier_event, .powerdown_or_irq_pin_out,
  .powerdown_or_irq_pin_oe, .powerdown_req, .page_select);

// ---- tb/pei_mgmt_host.sv ----
// Management controller model driving the register port
`timescale 1ns/1ps
module pei_mgmt_host
  import pei_pkg::*;
(
  // Clock
  input  wire logic              sys_clk,
  // Register port
  output logic      [ADDR_W-1:0] reg_addr,
  output logic                   reg_wr,
  output logic                   reg_rd,
  output logic      [DATA_W-1:0] reg_wdata,
  input  wire logic [DATA_W-1:0] reg_rdata,
  input  wire logic              reg_rvalid
);
  initial begin
    reg_addr = 5'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // After a write the data lines, and after a read the address lines, show inverted values so stale values never look valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~v;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 v = reg_rvalid ? reg_rdata : 16'hxxxx;
  endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the port event interrupt block
`timescale 1ns/1ps
module tb;
  import pei_pkg::*;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr;
  logic              reg_wr, reg_rd, reg_rvalid, pin_out, pin_oe, pd_req;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
  logic [5:0]        ev = 6'h00;
  logic              fc_ev = 1'b0;
  logic              rx_msb = 1'b0;
  logic              ext_pin = 1'b1;
  logic [PAGE_W-1:0] page_select;
  int                failures = 0;
  int                n_tests = 0;
  int                pend = 0, en = 0, ctrl = 0, fc = 0, r;

  always #2.5 sys_clk = ~sys_clk;
  pei_mgmt_host host (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid);
  pei_event_irq DUT (.sys_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
    .link_quality_event(ev[5]), .energy_detect_event(ev[4]), .link_change_event(ev[3]),
    .speed_change_event(ev[2]), .duplex_change_event(ev[1]), .autoneg_done_event(ev[0]),
    .false_carrier_event(fc_ev), .rx_error_count_msb(rx_msb),
    .powerdown_or_irq_pin_in(pin_oe ? pin_out : ext_pin), .powerdown_or_irq_pin_out(pin_out),
    .powerdown_or_irq_pin_oe(pin_oe), .powerdown_req(pd_req), .page_select);

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic st_chk();
    rd_chk(ADDR_EVT_STATUS, {pend[7:0], en[7:0]});
    pend = 0;
  endtask
  task automatic pulse(input int i);
    @(posedge sys_clk);
    ev <= 6'(1 << i);
    pend |= 1 << (i + 2);
    @(posedge sys_clk);
    ev <= 6'h00;
  endtask
  task automatic fc_tick();
    @(posedge sys_clk);
    fc_ev <= 1'b1;
    @(posedge sys_clk);
    fc_ev <= 1'b0;
    if (fc < 255) fc++;
    if (fc == 128) pend |= 2;
  endtask
  // Pin is low while an interrupt is active; allow the two-cycle path to settle
  task automatic pin_chk();
    repeat (3) @(posedge sys_clk);
    #1 chk(16'(pin_out), 16'(!(ctrl[2] || (ctrl[1] && (pend & en) != 0))));
  endtask
  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #50000;
    failures++;
    conclude();
  end

  initial begin
    r = $urandom(18);
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(ADDR_INT_CTRL, 16'h0000);
    st_chk();
    rd_chk(ADDR_PAGE_SEL, 16'h0000);
    rd_chk(ADDR_FC_COUNT, 16'h0000);
    r = $urandom;
    host.wr(ADDR_EVT_STATUS, r[15:0]);
    en = r & 255;
    st_chk();
    for (int i = 0; i < 6; i++) begin
      pulse(i);
      st_chk();
      st_chk();
    end
    for (int k = 0; k < 300; k++) begin
      fc_tick();
      if (fc == 128) st_chk();
    end
    host.wr(ADDR_FC_COUNT, 16'h0055);
    rd_chk(ADDR_FC_COUNT, 16'(fc));
    fc = 0;
    rd_chk(ADDR_FC_COUNT, 16'(fc));
    @(posedge sys_clk) rx_msb <= 1'b1;
    pend |= 1;
    st_chk();
    rx_msb <= 1'b0;
    host.wr(ADDR_INT_CTRL, 16'hfff3);
    ctrl = 3;
    host.wr(ADDR_EVT_STATUS, 16'h0010);
    en = 16;
    pulse(2);
    pin_chk();
    st_chk();
    pin_chk();
    pulse(0);
    pin_chk();
    host.wr(ADDR_INT_CTRL, 16'h0001);
    ctrl = 1;
    pulse(2);
    pin_chk();
    host.wr(ADDR_INT_CTRL, 16'h0005);
    ctrl = 5;
    pin_chk();
    rd_chk(ADDR_INT_CTRL, 16'(ctrl));
    host.wr(ADDR_INT_CTRL, 16'h0000);
    ext_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1 chk(16'(pd_req), 16'h0001);
    ext_pin <= 1'b1;
    r = $urandom;
    host.wr(ADDR_PAGE_SEL, r[15:0]);
    rd_chk(ADDR_PAGE_SEL, 16'(r & 3));
    host.wr(ADDR_PAGE_SEL, 16'hfffe);
    fc_tick();
    rd_chk(ADDR_FC_COUNT, 16'h0000);
    host.wr(ADDR_PAGE_SEL, 16'h0000);
    rd_chk(ADDR_FC_COUNT, 16'(fc));
    rd_chk(5'h10, 16'h0000);
    conclude();
  end
endmodule
